// ### adc_ctrl_map.svh
`ifndef ADC_CTRL_MAP_SVH
`define ADC_CTRL_MAP_SVH
// register byte offsets
`define CFG_OFS 8'h00
`define STAT_OFS 8'h04
`define RES_OFS 8'h08
`define SEL_OFS 8'h0c
// configuration byte fields
`define CFG_ADDR_LSB 0
`define CFG_DIFFERENTIAL_SELECT_BIT_BIT 3
`define CFG_BIP_BIT 4
`define CFG_INH_BIT 5
`define CFG_PD_BIT 6
`define CFG_EN_BIT 7
// status word fields
`define STAT_BUSY_BIT 0
`define STAT_PD_BIT 1
`define STAT_REF_BIT 2
`define STAT_MODE_LSB 3
`define STAT_VSS_BIT 5
// reset values
`define RST_BYTE 8'h00
`define RST_NIB 4'h0
`define RST_WORD 32'h0000_0000
`define RST_PTR 3'h0
`define RST_CNT 17'h0_0000
// strapped channel sets
`define HW_SE8_MASK 8'hff
`define HW_DIFF4_MASK 8'h55
// timing
`define PCLK_MHZ 25
`define REF_INT_SETTLE_MS 5
`define REF_EXT_SETTLE_US 50
`define REF_EXT_CYCLES 17'(`REF_EXT_SETTLE_US * `PCLK_MHZ)
`define CONV_EDGES_PER_CH 5'(9 * 2)
`endif

// ### adc_ctrl_pkg.sv
package adc_ctrl_pkg;
   // how the conversion type is chosen
   typedef enum logic [1:0] {MODE_REG, MODE_SE8, MODE_DIFF4} strap_mode_t;
   typedef enum logic [1:0] {SEQ_IDLE, SEQ_RUN} seq_phase_t;
   typedef struct packed {
      logic [4:0] s1;
      logic [4:0] s2;
      logic [4:0] s3;
      logic [4:0] stable;
      logic rise;
   } sync_state_t;
   typedef struct packed {
      seq_phase_t st;
      logic [7:0] rem;
      logic [2:0] ch;
      logic [4:0] cnt;
      logic store;
      logic done;
   } seq_state_t;
   typedef struct packed {
      logic [7:0] cfg_en;
      logic [7:0] cfg_differential_select_bit;
      logic [7:0] cfg_bip;
      logic [3:0] pol;
      logic [7:0] act_differential_select_bit;
      logic [7:0] act_bip;
      logic [7:0] conv_mask;
      logic [7:0] conv_differential_select_bit;
      logic [7:0] conv_bip;
      logic [3:0] conv_pol;
      logic pd;
      logic [7:0] last_cfg;
      logic [2:0] rd_ptr;
      logic [7:0][7:0] mem;
      logic busy_n;
      logic start;
      logic sample_all;
      logic [2:0] mux_pos;
      logic [2:0] mux_neg;
      logic mux_neg_gnd;
      logic mux_bip;
      logic [31:0] prdata;
      logic pslverr;
      logic [16:0] settle_cnt;
      logic ref_ready;
   } ctrl_state_t;
endpackage

// ### seq_if.sv
`timescale 1ns/100ps
`default_nettype none
interface seq_if;
   logic start;
   logic [7:0] mask;
   logic conv_edge;
   logic [2:0] ch;
   logic store;
   logic done;
   logic busy;
   modport ctrl (output start, mask, conv_edge, input ch, store, done, busy);
   modport seq (input start, mask, conv_edge, output ch, store, done, busy);
endinterface
`default_nettype wire

// ### pin_sync.sv
`timescale 1ns/100ps
`default_nettype none
module pin_sync (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [4:0] pins_async,
   output logic [4:0] pins_stable,
   output logic conv_rise
);
   import adc_ctrl_pkg::*;
   sync_state_t s_r, s_nxt;
   ////////////////////////////////////////////////////////////////////////
   // three stages; a change counts only when stages two and three agree
   always_comb begin
      s_nxt = s_r;
      s_nxt.s1 = pins_async;
      s_nxt.s2 = s_r.s1;
      s_nxt.s3 = s_r.s2;
      s_nxt.rise = 1'b0;
      for (int i = 0; i < 5; i++) begin
         if (s_r.s2[i] == s_r.s3[i]) begin
            s_nxt.stable[i] = s_r.s3[i];
         end
      end
      // conversion clock pin is bit 4
      s_nxt.rise = (s_r.s2[4] == s_r.s3[4]) && s_r.s3[4] && !s_r.stable[4];
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
   assign pins_stable = s_r.stable;
   assign conv_rise = s_r.rise;
endmodule
`default_nettype wire

// ### conv_seq.sv
`timescale 1ns/100ps
`default_nettype none
`include "adc_ctrl_map.svh"
module conv_seq (
   input wire logic pclk,
   input wire logic presetn,
   seq_if.seq bus
);
   import adc_ctrl_pkg::*;
   seq_state_t s_r, s_nxt;
   logic [7:0] left;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   function automatic logic [2:0] lowest(input logic [7:0] m);
      logic [2:0] r;
      r = 3'h0;
      for (int i = 7; i >= 0; i--) begin
         if (m[i]) begin
            r = 3'(i);
         end
      end
      return r;
   endfunction
   ////////////////////////////////////////////////////////////////////////
   // walk selected channels upward, one slot of conversion edges each
   always_comb begin
      s_nxt = s_r;
      s_nxt.store = 1'b0;
      s_nxt.done = 1'b0;
      left = s_r.rem & ~(8'h01 << s_r.ch);
      unique case (s_r.st)
         SEQ_IDLE: begin
            if (bus.start) begin
               s_nxt.rem = bus.mask;
               s_nxt.ch = lowest(bus.mask);
               s_nxt.cnt = 5'h00;
               if (bus.mask == 8'h00) begin
                  s_nxt.done = 1'b1;
               end else begin
                  s_nxt.st = SEQ_RUN;
               end
            end
         end
         SEQ_RUN: begin
            // first partial period before edge one is the start uncertainty
            if (bus.conv_edge) begin
               s_nxt.cnt = 5'(s_r.cnt + 5'h01);
               if (s_r.cnt == 5'(`CONV_EDGES_PER_CH - 5'h01)) begin
                  s_nxt.store = 1'b1;
                  s_nxt.cnt = 5'h00;
                  s_nxt.rem = left;
                  s_nxt.ch = lowest(left);
                  if (left == 8'h00) begin
                     s_nxt.done = 1'b1;
                     s_nxt.st = SEQ_IDLE;
                     s_nxt.ch = s_r.ch;
                  end
               end
            end
         end
      endcase
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
   // store names the channel that just finished
   assign bus.ch = s_r.store ? s_nxt.ch : s_r.ch;
   assign bus.store = s_nxt.store;
   assign bus.done = s_r.done;
   assign bus.busy = (s_r.st == SEQ_RUN);
   ////////////////////////////////////////////////////////////////////////
   // helper: edges seen in the current conversion
   logic [7:0] edges_h;
   logic [7:0] mask_h;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         edges_h <= 8'h00;
         mask_h <= 8'h00;
      end else if (bus.start && s_r.st == SEQ_IDLE) begin
         edges_h <= 8'h00;
         mask_h <= bus.mask;
      end else if (bus.conv_edge && s_r.st == SEQ_RUN) begin
         edges_h <= 8'(edges_h + 8'h01);
      end
   end
   AST_EDGE_TOTAL: assert property (s_r.done
      |-> edges_h == 8'(18 * $countones(mask_h)))
      else $error("conversion length not eighteen edges per channel");
   AST_NO_EARLY_STORE: assert property ($rose(bus.busy)
      |-> !s_r.store [*8])
      else $error("result stored too soon after start");
endmodule
`default_nettype wire

// ### adc_mode_pd_ctrl.sv
// Overview of operation
// - floating strap means register sets conversion type
// - strap low gives eight single-ended channels
// - strap high gives four differential pairs
// - in register mode, writing power-down bit one powers down
// - powered down still takes writes, keeps contents
// - powered down returns no results, starts nothing
// - power-down change acts on loading write
// - reference off in power-down; host waits settling
// - eighteen conversion clocks per selected channel
// - total includes one clock of start uncertainty
// - address lsb swaps differential pair polarity
// - polarity swap applies to same write's conversion
// - negative unipolar differential input reads zero
// - address 001 differential_select_bit bip selects pair one-zero
// - all channels sampled together at start
// - in register mode, conversion starts only when inhibit bit zero
// - busy low during conversion, high once stored
`timescale 1ns/100ps
`default_nettype none
`include "adc_ctrl_map.svh"
module adc_mode_pd_ctrl #(
   parameter logic [16:0] REF_INT_CYCLES =
      17'(`REF_INT_SETTLE_MS * 1000 * `PCLK_MHZ)
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic mode_strap_level,
   input wire logic mode_strap_float,
   input wire logic vss_negative,
   input wire logic conv_clk_pin,
   input wire logic ref_external,
   input wire logic [8:0] adc_code,
   output logic busy_n,
   output logic sample_all,
   output logic internal_reference_output_en,
   output logic powered_down,
   output logic [2:0] mux_pos,
   output logic [2:0] mux_neg,
   output logic mux_neg_gnd,
   output logic mux_bipolar
);
   import adc_ctrl_pkg::*;
   ctrl_state_t s_r, s_nxt;
   logic [4:0] pins_stable;
   logic conv_rise;
   strap_mode_t strap;
   logic vss_neg;
   logic ref_ext;
   logic setup;
   logic access;
   logic wr_cfg;
   seq_if sif ();
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////////////////////////////////////
   // pins are foreign to pclk; all pass the three-stage filter
   pin_sync u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .pins_async({conv_clk_pin, ref_external, vss_negative,
                   mode_strap_float, mode_strap_level}),
      .pins_stable(pins_stable),
      .conv_rise(conv_rise)
   );
   conv_seq u_seq (
      .pclk(pclk),
      .presetn(presetn),
      .bus(sif.seq)
   );
   assign sif.start = s_r.start;
   assign sif.mask = s_r.conv_mask;
   assign sif.conv_edge = conv_rise;
   ////////////////////////////////////////////////////////////////////////
   // strap decode
   always_comb begin
      if (pins_stable[1]) begin
         strap = MODE_REG;
      end else if (pins_stable[0]) begin
         strap = MODE_DIFF4;
      end else begin
         strap = MODE_SE8;
      end
   end
   assign vss_neg = pins_stable[2];
   assign ref_ext = pins_stable[3];
   // next selected channel after p, wrapping round
   function automatic logic [2:0] next_sel(input logic [7:0] m,
                                           input logic [2:0] p);
      logic [2:0] r;
      logic f;
      r = p;
      f = 1'b0;
      for (int i = 1; i <= 8; i++) begin
         if (!f && m[3'(p + 3'(i))]) begin
            r = 3'(p + 3'(i));
            f = 1'b1;
         end
      end
      return r;
   endfunction
   function automatic logic addr_ok(input logic [7:0] a);
      return a == `CFG_OFS || a == `STAT_OFS || a == `RES_OFS ||
             a == `SEL_OFS;
   endfunction
   assign setup = psel && !penable;
   assign access = psel && penable;
   assign wr_cfg = access && pwrite && paddr == `CFG_OFS;
   ////////////////////////////////////////////////////////////////////////
   // whole next state in one place
   always_comb begin
      logic [2:0] ca;
      logic [2:0] ev;
      logic [2:0] od;
      logic go;
      logic [2:0] c;
      ca = pwdata[`CFG_ADDR_LSB +: 3];
      ev = {ca[2:1], 1'b0};
      od = {ca[2:1], 1'b1};
      go = 1'b0;
      c = sif.ch;
      s_nxt = s_r;
      s_nxt.start = 1'b0;
      s_nxt.sample_all = 1'b0;
      // configuration write, taken at the end of the access phase
      if (wr_cfg) begin
         if (strap == MODE_REG) begin
            s_nxt.last_cfg = pwdata[7:0];
            if (pwdata[`CFG_DIFFERENTIAL_SELECT_BIT_BIT]) begin
               s_nxt.cfg_en[ev] = pwdata[`CFG_EN_BIT];
               s_nxt.cfg_en[od] = 1'b0;
               s_nxt.cfg_differential_select_bit[ev] = 1'b1;
               s_nxt.cfg_differential_select_bit[od] = 1'b0;
               s_nxt.cfg_bip[ev] = pwdata[`CFG_BIP_BIT];
               s_nxt.pol[ca[2:1]] = ca[0];
            end else begin
               s_nxt.cfg_en[ca] = pwdata[`CFG_EN_BIT];
               s_nxt.cfg_differential_select_bit[ca] = 1'b0;
               s_nxt.cfg_bip[ca] = pwdata[`CFG_BIP_BIT];
            end
            s_nxt.pd = pwdata[`CFG_PD_BIT];
            if (pwdata[`CFG_INH_BIT]) begin
               s_nxt.rd_ptr = ca;
            end
            go = !pwdata[`CFG_INH_BIT];
         end else begin
            go = 1'b1;
         end
      end
      // a new start is ignored while powered down or still converting
      if (go && !s_nxt.pd && s_r.busy_n) begin
         s_nxt.start = 1'b1;
         s_nxt.sample_all = 1'b1;
         s_nxt.busy_n = 1'b0;
         if (strap == MODE_REG) begin
            // type bits lag one conversion, polarity does not
            s_nxt.conv_mask = s_nxt.cfg_en;
            s_nxt.conv_differential_select_bit = s_r.act_differential_select_bit;
            s_nxt.conv_bip = s_r.act_bip;
            s_nxt.conv_pol = s_nxt.pol;
            s_nxt.act_differential_select_bit = s_nxt.cfg_differential_select_bit;
            s_nxt.act_bip = s_nxt.cfg_bip;
         end else begin
            s_nxt.conv_mask = (strap == MODE_SE8) ? `HW_SE8_MASK
                                                  : `HW_DIFF4_MASK;
            s_nxt.conv_differential_select_bit = (strap == MODE_SE8) ? 8'h00 : `HW_DIFF4_MASK;
            s_nxt.conv_bip = {8{vss_neg}};
            s_nxt.conv_pol = `RST_NIB;
         end
         s_nxt.rd_ptr = next_sel(s_nxt.conv_mask, 3'h7);
      end
      // result store; unipolar clamps negative differences to zero
      if (sif.store) begin
         if (s_r.conv_bip[c]) begin
            s_nxt.mem[c] = adc_code[8:1];
         end else begin
            s_nxt.mem[c] = adc_code[8] ? 8'h00 : adc_code[7:0];
         end
      end
      if (sif.done) begin
         s_nxt.busy_n = 1'b1;
      end
      // analog mux follows the channel being converted
      s_nxt.mux_bip = s_r.conv_bip[c];
      if (s_r.conv_differential_select_bit[c]) begin
         s_nxt.mux_pos = {c[2:1], s_r.conv_pol[c[2:1]]};
         s_nxt.mux_neg = {c[2:1], !s_r.conv_pol[c[2:1]]};
         s_nxt.mux_neg_gnd = 1'b0;
      end else begin
         s_nxt.mux_pos = c;
         s_nxt.mux_neg = 3'h0;
         s_nxt.mux_neg_gnd = 1'b1;
      end
      // reference settling; host must not convert before ready
      if (s_nxt.pd) begin
         s_nxt.settle_cnt = `RST_CNT;
         s_nxt.ref_ready = 1'b0;
      end else if (!s_r.ref_ready) begin
         if (s_r.settle_cnt >= (ref_ext ? `REF_EXT_CYCLES
                                        : REF_INT_CYCLES)) begin
            s_nxt.ref_ready = 1'b1;
         end else begin
            s_nxt.settle_cnt = 17'(s_r.settle_cnt + 17'h0_0001);
         end
      end
      // read data is prepared in the setup cycle
      if (setup) begin
         s_nxt.prdata = `RST_WORD;
         s_nxt.pslverr = !addr_ok(paddr) || (pwrite && paddr != `CFG_OFS);
         if (!pwrite) begin
            unique case (paddr)
               `CFG_OFS: s_nxt.prdata = {24'h00_0000, s_r.last_cfg};
               `STAT_OFS: begin
                  s_nxt.prdata[`STAT_BUSY_BIT] = !s_r.busy_n;
                  s_nxt.prdata[`STAT_PD_BIT] = s_r.pd;
                  s_nxt.prdata[`STAT_REF_BIT] = s_r.ref_ready;
                  s_nxt.prdata[`STAT_MODE_LSB +: 2] = strap;
                  s_nxt.prdata[`STAT_VSS_BIT] = vss_neg;
               end
               `RES_OFS: begin
                  if (!s_r.pd) begin
                     s_nxt.prdata = {24'h00_0000, s_r.mem[s_r.rd_ptr]};
                  end
               end
               `SEL_OFS: s_nxt.prdata = {24'h00_0000, s_r.conv_mask};
               default: s_nxt.prdata = `RST_WORD;
            endcase
         end
      end
      // each result read while powered up steps to the next selected channel
      if (access && !pwrite && paddr == `RES_OFS && !s_r.pd) begin
         s_nxt.rd_ptr = next_sel(s_r.conv_mask, s_r.rd_ptr);
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '0;
         s_r.busy_n <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // outputs
   assign prdata = s_r.prdata;
   assign pready = 1'b1;
   assign pslverr = s_r.pslverr;
   assign busy_n = s_r.busy_n;
   assign sample_all = s_r.sample_all;
   assign internal_reference_output_en = !s_r.pd;
   assign powered_down = s_r.pd;
   assign mux_pos = s_r.mux_pos;
   assign mux_neg = s_r.mux_neg;
   assign mux_neg_gnd = s_r.mux_neg_gnd;
   assign mux_bipolar = s_r.mux_bip;
   ////////////////////////////////////////////////////////////////////////
   // checks
   sequence conv_launch;
      s_r.sample_all && !s_r.busy_n;
   endsequence
   sequence conv_release;
      sif.done ##1 s_r.busy_n;
   endsequence
   AST_LAUNCH: assert property (s_r.start |-> conv_launch)
      else $error("start without sampling or busy");
   AST_BUSY_END: assert property (sif.done |-> conv_release)
      else $error("busy not released after last store");
   AST_SEQ_BUSY: assert property (sif.busy |-> !s_r.busy_n)
      else $error("sequencer running with busy released");
   AST_PD_NO_START: assert property (s_r.start |-> !s_r.pd)
      else $error("conversion started while powered down");
   AST_PD_READ_ZERO: assert property (setup && !pwrite
      && paddr == `RES_OFS && s_r.pd |=> prdata == `RST_WORD)
      else $error("result returned while powered down");
   AST_PD_WRITE: assert property (wr_cfg && strap == MODE_REG
      |=> s_r.pd == $past(pwdata[`CFG_PD_BIT]))
      else $error("power-down bit not loaded by write");
   AST_RETAIN: assert property (s_r.pd && !wr_cfg
      |=> $stable(s_r.cfg_en) && $stable(s_r.mem))
      else $error("contents lost while powered down");
   AST_REF_WAIT: assert property ($fell(s_r.pd)
      |-> !s_r.ref_ready [*8])
      else $error("reference ready too soon after power-up");
   AST_HARD_IGNORE: assert property (wr_cfg && strap != MODE_REG
      && s_r.busy_n && !s_r.pd |=> s_r.start && $stable(s_r.last_cfg))
      else $error("strapped write did not start or touched config");
   AST_HARD_SETS: assert property (wr_cfg && strap == MODE_DIFF4
      && s_r.busy_n && !s_r.pd |=> s_r.conv_mask == 8'h55
      && s_r.conv_differential_select_bit == 8'h55)
      else $error("strapped differential set wrong");
   AST_PAIR_ONE_ZERO: assert property (wr_cfg
      && strap == MODE_REG && pwdata[4:0] == 5'h19
      |=> s_r.cfg_differential_select_bit[0] && s_r.cfg_bip[0] && s_r.pol[0])
      else $error("pair one-zero not selected");
   AST_POL_NOW: assert property (wr_cfg && strap == MODE_REG
      && pwdata[3] && !pwdata[5] && !pwdata[6] && s_r.busy_n
      |=> s_r.conv_pol[$past(pwdata[2:1])] == $past(pwdata[0]))
      else $error("polarity swap delayed");
   AST_UNI_ZERO: assert property (sif.store
      && !s_r.conv_bip[sif.ch] && adc_code[8]
      |=> s_r.mem[$past(sif.ch)] == 8'h00)
      else $error("negative unipolar input not zero");
endmodule
`default_nettype wire

// ### adc_front_model.sv
`timescale 1ns/100ps
`default_nettype none
// analog core and conversion clock source beside the control block
module adc_front_model (
   input wire logic pclk,
   input wire logic sample_all,
   input wire logic [7:0][7:0] live,
   input wire logic [2:0] mux_pos,
   input wire logic [2:0] mux_neg,
   input wire logic mux_neg_gnd,
   output logic conv_clk_pin,
   output logic [8:0] adc_code
);
   logic [7:0][7:0] held;
   logic clk_lvl = 1'b0;
   int k = 0;
   // free clock, five pclk a level so the pin filter keeps up
   always @(posedge pclk) begin
      k <= (k == 4) ? 0 : k + 1;
      if (k == 4) clk_lvl <= ~clk_lvl;
   end
   assign conv_clk_pin = clk_lvl;
   // all track/holds capture together
   always @(posedge pclk) if (sample_all === 1'b1) held <= live;
   // signed pair difference, negative side may be ground
   assign adc_code = {1'b0, held[mux_pos]} -
      (mux_neg_gnd ? 9'h000 : {1'b0, held[mux_neg]});
endmodule
`default_nettype wire

// ### testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import adc_ctrl_pkg::*;
   localparam int P = 10;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, flt = 1'b1, lvl = 1'b0, vss = 1'b0, ref_ext = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, conv_clk, busy_n, smp, ref_en, pd, ngnd, bipolar_select_bit;
   logic [2:0] mpos, mneg;
   logic [8:0] code;
   logic [7:0][7:0] live, old;
   int failures = 0, n_tests = 0, seed = 92, cycles = 0, n;
   always #20 pclk = ~pclk;
   adc_mode_pd_ctrl #(.REF_INT_CYCLES(17'd32)) i_dut (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .mode_strap_level(lvl), .mode_strap_float(flt),
      .vss_negative(vss), .conv_clk_pin(conv_clk), .ref_external(ref_ext),
      .adc_code(code), .busy_n(busy_n), .sample_all(smp),
      .internal_reference_output_en(ref_en), .powered_down(pd),
      .mux_pos(mpos), .mux_neg(mneg), .mux_neg_gnd(ngnd), .mux_bipolar(bipolar_select_bit));
   adc_front_model i_fe (.pclk(pclk), .sample_all(smp), .live(live),
      .mux_pos(mpos), .mux_neg(mneg), .mux_neg_gnd(ngnd),
      .conv_clk_pin(conv_clk), .adc_code(code));
   ////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [31:0] s, e);
      n_tests++;
      if (s !== e) begin
         failures++;
         $display("unexpected %s: expected %h seen %h", what, e, s);
      end
   endtask
   task automatic final_report;
      $display("failures %0d n_tests %0d", failures, n_tests);
      if (failures == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // one apb transfer, request held until pready is seen
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // config write, then count cycles until busy clears
   task automatic conv(input logic [7:0] b, input logic go);
      apb(1'b1, 8'h00, {24'h0, b});
      @(negedge pclk);
      check("busy_n", busy_n, !go);
      check("sample_all", smp, go);
      if (go) begin
         // track/holds take live at the next edge; keep what they took
         @(posedge pclk);
         old = live;
         live <= {$random(seed), $random(seed)};
      end
      n = 0;
      while (busy_n !== 1'b1 && n < 3000) begin
         @(negedge pclk);
         n++;
      end
   endtask
   // busy window spans 18 clocks a channel, less one of start jitter
   task automatic dur(input int c);
      check("conv time", n >= (18*c-1)*P && n <= 18*c*P+12, 1);
   endtask
   function automatic logic [7:0] res(input int p, q, input logic g, b);
      logic [8:0] d;
      d = {1'b0, old[p]} - (g ? 9'h000 : {1'b0, old[q]});
      if (b) return d[8:1];
      return d[8] ? 8'h00 : d[7:0];
   endfunction
   // cut a hang short
   always @(posedge pclk) begin
      cycles++;
      if (cycles > 20000) begin
         failures++;
         final_report;
      end
   end
   ////////////////////////////////////////////////////////////////////
   initial begin
      live = {$random(seed), $random(seed)};
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      repeat (6) @(posedge pclk);
      apb(1'b0, 8'h10, 0);
      check("bad addr", err, 1);
      apb(1'b1, 8'h04, 0);
      check("ro write", err, 1);
      apb(1'b0, 8'h04, 0);
      check("mode", rd[5:3], 3'h0);
      conv(8'hb9, 1'b0);
      conv(8'ha2, 1'b0);
      // first run is the dummy while the type bits land
      repeat (2) conv(8'h82, 1'b1);
      dur(2);
      apb(1'b0, 8'h0c, 0);
      check("mask", rd, 32'h05);
      apb(1'b0, 8'h08, 0);
      check("pair", rd, res(1, 0, 0, 1));
      apb(1'b0, 8'h08, 0);
      check("ch2", rd, res(2, 0, 1, 0));
      conv(8'h98, 1'b1);
      apb(1'b0, 8'h08, 0);
      check("swap", rd, res(0, 1, 0, 1));
      conv(8'he2, 1'b0);
      check("pd", pd, 1);
      check("ref", ref_en, 0);
      apb(1'b0, 8'h08, 0);
      check("pd read", rd, 0);
      apb(1'b0, 8'h04, 0);
      check("pd status", rd[2:1], 2'b01);
      conv(8'hc2, 1'b0);
      apb(1'b0, 8'h00, 0);
      check("cfg", rd, 32'hc2);
      conv(8'ha2, 1'b0);
      check("pd off", pd, 0);
      apb(1'b0, 8'h04, 0);
      check("ref settling", rd[2], 0);
      repeat (40) @(posedge pclk); // reference recharge wait
      apb(1'b0, 8'h04, 0);
      check("ref ready", rd[2], 1);
      conv(8'h82, 1'b1);
      apb(1'b0, 8'h08, 0);
      check("kept", rd, res(0, 1, 0, 1));
      // type bits lag one run, the polarity bit does not
      conv(8'h89, 1'b1);
      apb(1'b0, 8'h08, 0);
      check("lag", rd, res(1, 0, 0, 1));
      // corner: pair driven negative in unipolar mode
      live[1] <= 8'h40;
      live[0] <= 8'hc0;
      conv(8'h89, 1'b1);
      apb(1'b0, 8'h08, 0);
      check("neg uni", rd, 32'h00);
      // external reference: host may start 50us after power-up
      ref_ext <= 1'b1;
      conv(8'he2, 1'b0);
      conv(8'ha2, 1'b0);
      repeat (1200) @(posedge pclk);
      apb(1'b0, 8'h04, 0);
      check("ext early", rd[2], 0);
      repeat (60) @(posedge pclk);
      apb(1'b0, 8'h04, 0);
      check("ext ready", rd[2], 1);
      // both driven strap levels with both supplies, random bus data
      for (int m = 0; m < 4; m++) begin
         flt <= 1'b0;
         lvl <= m[0];
         vss <= m[1];
         repeat (6) @(posedge pclk);
         apb(1'b0, 8'h04, 0);
         check("strap", rd[5:3], {m[1], m[0], !m[0]});
         conv($random(seed), 1'b1);
         dur(m[0] ? 4 : 8);
         apb(1'b0, 8'h0c, 0);
         check("set", rd, m[0] ? 32'h55 : 32'hff);
         check("mux bip", bipolar_select_bit, m[1]);
         check("neg gnd", ngnd, !m[0]);
      end
      final_report;
   end
endmodule
`default_nettype wire
